// File: design/sebs_pkg.sv
package sebs_pkg;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int SEBS_ADDR_W = 11;
  localparam logic [4:0] SEBS_PAGE_BYTES = 5'h10;
  localparam int SEBS_FIFO_W = 19;
  localparam int SEBS_FIFO_DEPTH = 32;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SEBS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SEBS_STATUS_OFS = 8'h04;
  localparam logic [7:0] SEBS_FIFO_OFS = 8'h08;
  localparam int SEBS_CTRL_SINGLE_BIT = 0;
  localparam logic SEBS_CTRL_SINGLE_RST = 1'b0;
  localparam int SEBS_STATUS_BUSY_BIT = 0;
  localparam int SEBS_STATUS_FIFO_BIT = 1;
  localparam int SEBS_STATUS_WP_BIT = 2;
  localparam int SEBS_FIFO_VALID_BIT = 31;
  localparam logic [1:0] SEBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SEBS_RESP_SLVERR = 2'h2;

  // ****************************************
  // Bus phases
  // ****************************************
  localparam logic [3:0] SEBS_BIT_LAST = 4'h7;
  localparam logic [3:0] SEBS_BIT_DONE = 4'h8;

  typedef enum logic [4:0] {
    SEBS_IDLE = 5'b00001,
    SEBS_RX   = 5'b00010,
    SEBS_ACK  = 5'b00100,
    SEBS_TX   = 5'b01000,
    SEBS_MACK = 5'b10000
  } sebs_state_e;

  typedef enum logic [3:0] {
    SEBS_K_SEL  = 4'b0001,
    SEBS_K_AHI  = 4'b0010,
    SEBS_K_ALO  = 4'b0100,
    SEBS_K_DATA = 4'b1000
  } sebs_kind_e;

endpackage

// File: design/sebs_fifo.sv
`timescale 1ns/100ps
module sebs_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] next_wr_ptr;
  logic [PW:0] next_rd_ptr;
  logic do_push;
  logic do_pop;

  // ****************************************
  // Flags
  // ****************************************
  assign in_ready = (wr_ptr[PW] == rd_ptr[PW]) || (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[PW-1:0]];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_push) begin
      next_wr_ptr = PW'(1) + wr_ptr;
    end
    if (do_pop) begin
      next_rd_ptr = PW'(1) + rd_ptr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

endmodule

// File: design/sebs_top.sv
`timescale 1ns/100ps
module sebs_top
  import sebs_pkg::*;
#(
  // Device type code; value is arbitrary
  parameter logic [3:0] TYPE_CODE = 4'h6
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  input wire logic chip_sel_bit2,
  input wire logic write_protect_input,
  // Memory read port
  output logic [SEBS_ADDR_W-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // Reset release and input filters
  // ****************************************
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [5:0] in_raw;
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] filt;
  logic [5:0] next_filt;
  logic scl_prev;
  logic sda_prev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign in_raw = {write_protect_input, chip_sel_bit2, chip_sel_bit1, chip_sel_bit0,
                   sda_in, scl_in};
  assign next_filt = (s2 & s3) | (filt & (s2 ^ s3));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 6'h03;
      s2 <= 6'h03;
      s3 <= 6'h03;
      filt <= 6'h03;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      s1 <= in_raw;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      scl_prev <= filt[0];
      sda_prev <= filt[1];
    end
  end

  logic scl_f;
  logic sda_f;
  logic [2:0] cs_f;
  logic wp_f;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign cs_f = filt[4:2];
  assign wp_f = filt[5];
  assign scl_rise = scl_f & ~scl_prev;
  assign scl_fall = ~scl_f & scl_prev;
  assign bus_start = scl_f & scl_prev & sda_prev & ~sda_f;
  assign bus_stop = scl_f & scl_prev & ~sda_prev & sda_f;

  // ****************************************
  // Bus state machine
  // ****************************************
  sebs_state_e state;
  sebs_state_e next_state;
  sebs_kind_e kind;
  sebs_kind_e next_kind;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic rw;
  logic next_rw;
  logic [SEBS_ADDR_W-1:0] ptr;
  logic [SEBS_ADDR_W-1:0] next_ptr;
  logic [4:0] wr_cnt;
  logic [4:0] next_wr_cnt;
  logic wr_pending;
  logic next_wr_pending;
  logic ack_en;
  logic next_ack_en;
  logic mack_ok;
  logic next_mack_ok;
  logic oe;
  logic next_oe;
  logic busy;
  logic next_busy;
  logic ctrl_single;
  logic clr_busy;
  logic [7:0] rx_byte;
  logic data_ok;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [SEBS_FIFO_W-1:0] fifo_out_data;

  assign rx_byte = {shift[6:0], sda_f};
  assign data_ok = ~wp_f & fifo_in_ready & (wr_cnt < SEBS_PAGE_BYTES)
                   & ~(ctrl_single & (wr_cnt != 5'h00));

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_cnt = cnt;
    next_shift = shift;
    next_tx_shift = tx_shift;
    next_rw = rw;
    next_ptr = ptr;
    next_wr_cnt = wr_cnt;
    next_wr_pending = wr_pending;
    next_ack_en = ack_en;
    next_mack_ok = mack_ok;
    next_oe = oe;
    next_busy = busy & ~clr_busy;
    fifo_in_valid = 1'b0;
    if (bus_start) begin
      next_state = SEBS_RX;
      next_kind = SEBS_K_SEL;
      next_cnt = 4'h0;
      next_oe = 1'b0;
      next_wr_cnt = 5'h00;
    end else if (bus_stop) begin
      next_state = SEBS_IDLE;
      next_oe = 1'b0;
      next_wr_pending = 1'b0;
      if (wr_pending) begin
        next_busy = 1'b1;
      end
    end else begin
      unique case (state)
        SEBS_IDLE: begin
          next_oe = 1'b0;
        end
        SEBS_RX: begin
          if (scl_rise) begin
            next_shift = rx_byte;
            next_cnt = 4'(cnt + 4'h1);
            if (cnt == SEBS_BIT_LAST) begin
              unique case (kind)
                SEBS_K_SEL: begin
                  next_rw = rx_byte[0];
                  next_ack_en = 1'b1;
                  if ((rx_byte[7:4] != TYPE_CODE) || (rx_byte[3:1] != cs_f) || busy) begin
                    next_state = SEBS_IDLE;
                    next_ack_en = 1'b0;
                  end
                end
                SEBS_K_AHI: begin
                  next_ack_en = 1'b1;
                end
                SEBS_K_ALO: begin
                  next_ack_en = 1'b1;
                end
                default: begin
                  next_ack_en = data_ok;
                  if (data_ok) begin
                    fifo_in_valid = 1'b1;
                    next_wr_cnt = 5'(wr_cnt + 5'h01);
                    next_wr_pending = 1'b1;
                  end
                end
              endcase
            end
          end else if (scl_fall && (cnt == SEBS_BIT_DONE)) begin
            next_state = SEBS_ACK;
            next_oe = ack_en;
          end
        end
        SEBS_ACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_cnt = 4'h0;
            next_state = SEBS_RX;
            unique case (kind)
              SEBS_K_SEL: begin
                if (rw) begin
                  next_state = SEBS_TX;
                  next_oe = ~mem_rd_data[7];
                  next_tx_shift = {mem_rd_data[6:0], 1'b0};
                end else begin
                  next_kind = SEBS_K_AHI;
                end
              end
              SEBS_K_AHI: begin
                next_ptr[SEBS_ADDR_W-1:8] = shift[2:0];
                next_kind = SEBS_K_ALO;
              end
              SEBS_K_ALO: begin
                next_ptr[7:0] = shift;
                next_kind = SEBS_K_DATA;
              end
              default: begin
                if (ack_en) begin
                  next_ptr[3:0] = 4'(ptr[3:0] + 4'h1);
                end else begin
                  next_state = SEBS_IDLE;
                end
              end
            endcase
          end
        end
        SEBS_TX: begin
          if (scl_rise) begin
            next_cnt = 4'(cnt + 4'h1);
          end else if (scl_fall) begin
            if (cnt == SEBS_BIT_DONE) begin
              next_oe = 1'b0;
              next_state = SEBS_MACK;
              next_ptr = SEBS_ADDR_W'(ptr + 11'h001);
            end else begin
              next_oe = ~tx_shift[7];
              next_tx_shift = {tx_shift[6:0], 1'b0};
            end
          end
        end
        SEBS_MACK: begin
          if (scl_rise) begin
            next_mack_ok = ~sda_f;
          end else if (scl_fall) begin
            next_cnt = 4'h0;
            if (mack_ok) begin
              next_state = SEBS_TX;
              next_oe = ~mem_rd_data[7];
              next_tx_shift = {mem_rd_data[6:0], 1'b0};
            end else begin
              next_state = SEBS_IDLE;
            end
          end
        end
        default: begin
          next_state = SEBS_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SEBS_IDLE;
      kind <= SEBS_K_SEL;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx_shift <= 8'h00;
      rw <= 1'b0;
      ptr <= 11'h000;
      wr_cnt <= 5'h00;
      wr_pending <= 1'b0;
      ack_en <= 1'b0;
      mack_ok <= 1'b0;
      oe <= 1'b0;
      busy <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      mem_rd_addr <= 11'h000;
    end else begin
      state <= next_state;
      kind <= next_kind;
      cnt <= next_cnt;
      shift <= next_shift;
      tx_shift <= next_tx_shift;
      rw <= next_rw;
      ptr <= next_ptr;
      wr_cnt <= next_wr_cnt;
      wr_pending <= next_wr_pending;
      ack_en <= next_ack_en;
      mack_ok <= next_mack_ok;
      oe <= next_oe;
      busy <= next_busy;
      sda_oe <= next_oe;
      sda_out <= 1'b0;
      mem_rd_addr <= next_ptr;
    end
  end

  // ****************************************
  // Write data buffer
  // ****************************************
  sebs_fifo #(
    .WIDTH(SEBS_FIFO_W),
    .DEPTH(SEBS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({ptr, rx_byte}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // Register slave
  // ****************************************
  logic aw_held;
  logic next_aw_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic w_strb0;
  logic next_w_strb0;
  logic next_ctrl_single;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb0 = w_strb0;
    next_ctrl_single = ctrl_single;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    clr_busy = 1'b0;
    fifo_out_ready = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb0 = s_axi_wstrb[0];
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = SEBS_RESP_OKAY;
      if ({aw_addr[7:2], 2'h0} == SEBS_CTRL_OFS) begin
        if (w_strb0) begin
          next_ctrl_single = w_data[SEBS_CTRL_SINGLE_BIT];
        end
      end else if ({aw_addr[7:2], 2'h0} == SEBS_STATUS_OFS) begin
        clr_busy = w_strb0 & w_data[SEBS_STATUS_BUSY_BIT];
      end else if ({aw_addr[7:2], 2'h0} != SEBS_FIFO_OFS) begin
        next_bresp = SEBS_RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = SEBS_RESP_OKAY;
      if ({s_axi_araddr[7:2], 2'h0} == SEBS_CTRL_OFS) begin
        next_rdata[SEBS_CTRL_SINGLE_BIT] = ctrl_single;
      end else if ({s_axi_araddr[7:2], 2'h0} == SEBS_STATUS_OFS) begin
        next_rdata[SEBS_STATUS_BUSY_BIT] = busy;
        next_rdata[SEBS_STATUS_FIFO_BIT] = fifo_out_valid;
        next_rdata[SEBS_STATUS_WP_BIT] = wp_f;
      end else if ({s_axi_araddr[7:2], 2'h0} == SEBS_FIFO_OFS) begin
        fifo_out_ready = 1'b1;
        next_rdata[SEBS_FIFO_VALID_BIT] = fifo_out_valid;
        if (fifo_out_valid) begin
          next_rdata[SEBS_FIFO_W-1:0] = fifo_out_data;
        end
      end else begin
        next_rresp = SEBS_RESP_SLVERR;
      end
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb0 <= 1'b0;
      ctrl_single <= SEBS_CTRL_SINGLE_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SEBS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SEBS_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb0 <= next_w_strb0;
      ctrl_single <= next_ctrl_single;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_byte_end;
    (state == SEBS_RX) && scl_rise && !bus_start && !bus_stop && (cnt == SEBS_BIT_LAST);
  endsequence
  sequence s_sel_end;
    s_byte_end ##0 (kind == SEBS_K_SEL);
  endsequence

  a_sel_wrong_pins: assert property (s_sel_end ##0 (rx_byte[3:1] != cs_f) |=>
    (state == SEBS_IDLE) && !ack_en) else $error("select with foreign pins not ignored");
  a_sel_wrong_type: assert property (s_sel_end ##0 (rx_byte[7:4] != TYPE_CODE) |=>
    (state == SEBS_IDLE)) else $error("select with wrong type not ignored");
  a_ack_drive_low: assert property ((state == SEBS_ACK) && ack_en |-> sda_oe)
    else $error("ack slot not driven low");
  a_wp_data_nack: assert property (s_byte_end ##0 (kind == SEBS_K_DATA) && wp_f |=>
    !ack_en && !$past(fifo_in_valid)) else $error("protected data byte accepted");
  a_page_limit: assert property (fifo_in_valid |-> (wr_cnt < SEBS_PAGE_BYTES))
    else $error("page write beyond sixteen bytes");
  a_single_write: assert property (fifo_in_valid && ctrl_single |-> (wr_cnt == 5'h00))
    else $error("multibyte write in single byte mode");
  a_stop_commit: assert property (bus_stop && wr_pending |=>
    busy && (state == SEBS_IDLE)) else $error("write cycle not started by stop");
  a_start_restart: assert property (bus_start |=>
    (state == SEBS_RX) && (kind == SEBS_K_SEL) && (cnt == 4'h0) && !sda_oe)
    else $error("start did not restart select");
  a_ptr_step: assert property ((state == SEBS_TX) && scl_fall && !bus_start
    && !bus_stop && (cnt == SEBS_BIT_DONE) |=> (ptr == 11'($past(ptr) + 11'h001)))
    else $error("read pointer did not step");
  a_open_drain: assert property (sda_oe |-> (state == SEBS_ACK) || (state == SEBS_TX))
    else $error("data line driven outside ack or send");
  a_master_nack: assert property ((state == SEBS_MACK) && scl_fall && !mack_ok
    && !bus_start && !bus_stop |=> (state == SEBS_IDLE)[*2])
    else $error("read went on after nack");

endmodule

// File: verification/sebs_mst.sv
`timescale 1ns/100ps
module sebs_mst (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic scl = 1'b1,
  output logic sda_low = 1'b0,
  input wire logic sda
);
  task automatic wq();
    repeat (8) @(posedge clk);
  endtask
  // Data changes only while clock low
  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    wq();
    scl <= 1'b1;
    wq();
    s = sda;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  // Start and stop framing
  task automatic start();
    sda_low <= 1'b0;
    wq();
    scl <= 1'b1;
    wq();
    sda_low <= 1'b1;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wq();
    scl <= 1'b1;
    wq();
    sda_low <= 1'b0;
    wq();
  endtask
  // Byte MSB first, then ninth slot; read bytes acked by ma
  task automatic xfer(input logic [7:0] tx, input logic ma, output logic [7:0] rx,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ma, ak);
  endtask
endmodule

// File: verification/sebs_top_test.sv
`timescale 1ns/100ps
module sebs_top_test;
  import sebs_pkg::*;
  localparam logic [3:0] TC = 4'h9; // Type code; value is arbitrary
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic scl, m_low, sda, sda_out, sda_oe;
  logic [10:0] ra, mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, seen;
  logic [31:0] exp_q[$], fifo_q[$];
  int n_mismatch = 0, n_checks = 0;
  event got;
  function automatic logic [7:0] mem(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h15};
  endfunction
  function automatic logic [7:0] sel(input logic rw);
    return {TC, cs, rw};
  endfunction
  always #4 clk = ~clk;
  assign sda = ~(m_low | (sda_oe & ~sda_out)); // Pulled-up open drain wire
  assign mem_rd_data = mem(mem_rd_addr);
  sebs_mst u_sebs_mst (.clk, .scl, .sda_low(m_low), .sda);
  sebs_top #(.TYPE_CODE(TC)) u_sebs_top (.clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .chip_sel_bit0(cs[0]), .chip_sel_bit1(cs[1]), .chip_sel_bit2(cs[2]),
    .write_protect_input(wp), .mem_rd_addr, .mem_rd_data, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Result watchers
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check({30'h0, s_axi_bresp}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      check({30'h0, s_axi_rresp}, exp_q.pop_front());
      check(s_axi_rdata, exp_q.pop_front());
    end
  end
  always @(got) check(seen, exp_q.pop_front());
  task automatic fin(input int n);
    @(posedge clk);
    if (n >= 200) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    exp_q.push_back({30'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    fin(n);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
    int n = 0;
    logic [1:0] r;
    r = SEBS_RESP_SLVERR;
    if (a == SEBS_CTRL_OFS || a == SEBS_STATUS_OFS || a == SEBS_FIFO_OFS) r = SEBS_RESP_OKAY;
    exp_q.push_back({30'h0, r});
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    fin(n);
  endtask
  // One byte on the bus; notes the ack bit or the byte read
  task automatic xf(input logic [7:0] tx, input logic ma, input logic [7:0] e, input logic rd);
    logic [7:0] rx;
    logic ak;
    exp_q.push_back({24'h0, e});
    u_sebs_mst.xfer(tx, ma, rx, ak);
    seen = rd ? {24'h0, rx} : {31'h0, ak};
    -> got;
  endtask
  task automatic bus_wr(input logic [10:0] a, input int nb, input int n_ok);
    logic [7:0] d;
    u_sebs_mst.start();
    xf(sel(1'b0), 1'b1, 8'h00, 1'b0);
    xf({5'h0, a[10:8]}, 1'b1, 8'h00, 1'b0);
    xf(a[7:0], 1'b1, 8'h00, 1'b0);
    for (int i = 0; i < nb; i++) begin
      d = 8'($urandom);
      xf(d, 1'b1, {7'h0, i >= n_ok}, 1'b0);
      if (i < n_ok) fifo_q.push_back({1'b1, 12'h0, a[10:4], a[3:0] + 4'(i), d});
    end
    u_sebs_mst.stop();
  endtask
  task automatic drain();
    while (fifo_q.size() > 0) axi_rd(SEBS_FIFO_OFS, fifo_q.pop_front());
    axi_rd(SEBS_FIFO_OFS, 32'h0);
  endtask
  initial begin
    void'($urandom(30377));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    cs <= 3'($urandom);
    repeat (20) @(posedge clk);
    axi_rd(SEBS_CTRL_OFS, 32'h0);
    axi_rd(SEBS_STATUS_OFS, 32'h0);
    axi_rd(8'h0C, 32'h0);
    axi_wr(8'h0C, 32'h1, SEBS_RESP_SLVERR);
    u_sebs_mst.start();
    xf(sel(1'b0), 1'b1, 8'h00, 1'b0);
    xf(8'h07, 1'b1, 8'h00, 1'b0);
    xf(8'hFF, 1'b1, 8'h00, 1'b0);
    u_sebs_mst.start();
    xf(sel(1'b1), 1'b1, 8'h00, 1'b0);
    xf(8'hFF, 1'b0, mem(11'h7FF), 1'b1);
    xf(8'hFF, 1'b1, mem(11'h000), 1'b1);
    u_sebs_mst.stop();
    u_sebs_mst.start();
    xf(sel(1'b1), 1'b1, 8'h00, 1'b0);
    xf(8'hFF, 1'b1, mem(11'h001), 1'b1);
    u_sebs_mst.stop();
    u_sebs_mst.start();
    xf({TC, ~cs, 1'b1}, 1'b1, 8'h01, 1'b0);
    u_sebs_mst.start();
    xf({~TC, cs, 1'b1}, 1'b1, 8'h01, 1'b0);
    u_sebs_mst.stop();
    ra = 11'($urandom);
    bus_wr(ra, 17, 16);
    axi_rd(SEBS_STATUS_OFS, 32'h3);
    u_sebs_mst.start();
    xf(sel(1'b0), 1'b1, 8'h01, 1'b0);
    u_sebs_mst.stop();
    axi_wr(SEBS_STATUS_OFS, 32'h1, SEBS_RESP_OKAY);
    bus_wr(~ra, 16, 16);
    axi_wr(SEBS_STATUS_OFS, 32'h1, SEBS_RESP_OKAY);
    bus_wr(ra, 1, 0);
    axi_rd(SEBS_STATUS_OFS, 32'h2);
    drain();
    wp <= 1'b1;
    repeat (8) @(posedge clk);
    axi_rd(SEBS_STATUS_OFS, 32'h4);
    bus_wr(ra, 1, 0);
    axi_rd(SEBS_STATUS_OFS, 32'h4);
    wp <= 1'b0;
    axi_wr(SEBS_CTRL_OFS, 32'h1, SEBS_RESP_OKAY);
    axi_rd(SEBS_CTRL_OFS, 32'h1);
    bus_wr(ra, 2, 1);
    axi_rd(SEBS_STATUS_OFS, 32'h3);
    drain();
    axi_wr(SEBS_STATUS_OFS, 32'h1, SEBS_RESP_OKAY);
    axi_rd(SEBS_STATUS_OFS, 32'h0);
    arst_n <= 1'b0;
    u_sebs_mst.start();
    xf(sel(1'b1), 1'b1, 8'h01, 1'b0);
    u_sebs_mst.stop();
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    axi_rd(SEBS_CTRL_OFS, 32'h0);
    report_and_stop();
  end
endmodule
